// file: rtl/serial_msg_pkg.sv
// Shared constants for the ASCII serial message port.
package serial_msg_pkg;

	localparam int unsigned CLK_HZ    = 20_000_000;
	localparam int unsigned BAUD_RATE = 57_600;
	localparam int unsigned CNT_W     = 9;
	localparam logic [CNT_W-1:0] BIT_CYCLES = CNT_W'(CLK_HZ / BAUD_RATE);
	localparam logic [CNT_W-1:0] HALF_BIT   = CNT_W'(CLK_HZ / BAUD_RATE / 2);

	localparam int unsigned CHAR_W      = 7;
	localparam int unsigned FRAME_BITS  = 10;
	localparam logic [3:0]  LAST_FRAME_BIT = 4'(FRAME_BITS - 1);
	localparam logic [2:0]  LAST_DATA_BIT  = 3'(CHAR_W - 1);

	localparam logic [CHAR_W-1:0] CHAR_LF   = 7'h0a;
	localparam logic [CHAR_W-1:0] CHAR_CR   = 7'h0d;
	localparam logic [CHAR_W-1:0] CHAR_SEMI = 7'h3b;

	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned BUF_DEPTH = 256;
	localparam int unsigned LEN_W     = 9;
	localparam logic [LEN_W-1:0] MAX_COMM_LEN = 9'h0ff;

	localparam logic [ADDR_W-1:0] ONE_ADDR = 8'h01;
	localparam logic [LEN_W-1:0]  ONE_LEN  = 9'h001;
	localparam logic [CNT_W-1:0]  ONE_CNT  = 9'h001;

endpackage

// file: rtl/char_buffer.sv
// Character store holding one received message; read data comes from a register.
`timescale 1ns/1ps
module char_buffer #(
	parameter int unsigned WIDTH  = serial_msg_pkg::CHAR_W,
	parameter int unsigned DEPTH  = serial_msg_pkg::BUF_DEPTH,
	parameter int unsigned ADDR_W = serial_msg_pkg::ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              ce,
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [WIDTH-1:0]  wr_data,
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [WIDTH-1:0]  rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= '0;
		end else if (ce) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// file: rtl/ascii_serial_message_port.sv
// Serial character framing, message splitting and response framing for the message port.
`timescale 1ns/1ps
module ascii_serial_message_port #(
	parameter int unsigned BUF_DEPTH = serial_msg_pkg::BUF_DEPTH
) (
	input  wire logic                               clk,
	input  wire logic                               arst_n,
	input  wire logic                               ce,
	input  wire logic                               rx_pin,
	output logic                                    tx_pin,
	output logic [serial_msg_pkg::CHAR_W-1:0]       msg_data,
	output logic                                    msg_valid,
	output logic                                    msg_last,
	input  wire logic                               msg_ready,
	output logic                                    msg_drop,
	input  wire logic [serial_msg_pkg::CHAR_W-1:0]  rsp_data,
	input  wire logic                               rsp_valid,
	input  wire logic                               rsp_end,
	output logic                                    rsp_ready
);
	import serial_msg_pkg::*;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_type;
	typedef enum logic [1:0] {MS_COLLECT, MS_FETCH, MS_SHOW} msg_state_type;
	typedef enum logic {TX_IDLE, TX_SEND} tx_state_type;
	typedef enum logic [1:0] {SRC_USER, SRC_CR, SRC_LF} tx_src_type;

	// Receive pin synchroniser; only the second and third stages are looked at.
	logic              sync1_reg, sync2_reg, sync3_reg, rx_level_reg;
	rx_state_type      rx_state_reg, rx_state_next;
	logic [CNT_W-1:0]  rx_cnt_reg, rx_cnt_next;
	logic [2:0]        rx_bit_reg, rx_bit_next;
	logic [CHAR_W-1:0] rx_shift_reg, rx_shift_next;
	logic              rx_par_reg, rx_par_next;
	logic              char_done_reg, char_done_next;
	logic              char_bad_reg, char_bad_next;

	msg_state_type     ms_state_reg, ms_state_next;
	logic [ADDR_W-1:0] wr_ptr_reg, wr_ptr_next;
	logic [ADDR_W-1:0] rd_idx_reg, rd_idx_next;
	logic [ADDR_W-1:0] len_reg, len_next;
	logic [LEN_W-1:0]  comm_len_reg, comm_len_next;
	logic              err_reg, err_next;
	logic              cr_pend_reg, cr_pend_next;
	logic              drop_reg, drop_next;
	logic              wr_en;
	logic              err_now;

	tx_state_type      tx_state_reg, tx_state_next;
	tx_src_type        src_reg, src_next;
	logic [FRAME_BITS-1:0] tx_shift_reg, tx_shift_next;
	logic [3:0]        tx_bit_reg, tx_bit_next;
	logic [CNT_W-1:0]  tx_cnt_reg, tx_cnt_next;
	logic              tx_pin_reg, tx_pin_next;
	logic [CHAR_W-1:0] load_char;
	logic              load;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg    <= 1'b1;
			sync2_reg    <= 1'b1;
			sync3_reg    <= 1'b1;
			rx_level_reg <= 1'b1;
		end else if (ce) begin
			sync1_reg <= rx_pin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			if (sync2_reg == sync3_reg) begin
				rx_level_reg <= sync3_reg;
			end
		end
	end

	// Receiver: bits are sampled at mid-period after a half-bit start check.
	always_comb begin
		rx_state_next  = rx_state_reg;
		rx_cnt_next    = rx_cnt_reg + ONE_CNT;
		rx_bit_next    = rx_bit_reg;
		rx_shift_next  = rx_shift_reg;
		rx_par_next    = rx_par_reg;
		char_done_next = 1'b0;
		char_bad_next  = char_bad_reg;
		unique case (rx_state_reg)
			RX_IDLE: begin
				rx_cnt_next = '0;
				if (!rx_level_reg) begin
					rx_state_next = RX_START;
				end
			end
			RX_START: begin
				if (rx_cnt_reg == HALF_BIT - ONE_CNT) begin
					rx_cnt_next   = '0;
					rx_bit_next   = '0;
					rx_state_next = rx_level_reg ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_cnt_reg == BIT_CYCLES - ONE_CNT) begin
					rx_cnt_next   = '0;
					rx_shift_next = {rx_level_reg, rx_shift_reg[CHAR_W-1:1]};
					rx_bit_next   = rx_bit_reg + 3'h1;
					if (rx_bit_reg == LAST_DATA_BIT) begin
						rx_state_next = RX_PARITY;
					end
				end
			end
			RX_PARITY: begin
				if (rx_cnt_reg == BIT_CYCLES - ONE_CNT) begin
					rx_cnt_next   = '0;
					rx_par_next   = rx_level_reg;
					rx_state_next = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rx_cnt_reg == BIT_CYCLES - ONE_CNT) begin
					char_done_next = 1'b1;
					// Odd parity and a high stop bit are both needed for a good character.
					char_bad_next  = !(^{rx_shift_reg, rx_par_reg}) || !rx_level_reg;
					rx_state_next  = RX_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_state_reg  <= RX_IDLE;
			rx_cnt_reg    <= '0;
			rx_bit_reg    <= '0;
			rx_shift_reg  <= '0;
			rx_par_reg    <= 1'b0;
			char_done_reg <= 1'b0;
			char_bad_reg  <= 1'b0;
		end else if (ce) begin
			rx_state_reg  <= rx_state_next;
			rx_cnt_reg    <= rx_cnt_next;
			rx_bit_reg    <= rx_bit_next;
			rx_shift_reg  <= rx_shift_next;
			rx_par_reg    <= rx_par_next;
			char_done_reg <= char_done_next;
			char_bad_reg  <= char_bad_next;
		end
	end

	// Message splitter. Characters that arrive while the previous message is still being
	// handed out cannot be stored, so the message they belong to is dropped.
	always_comb begin
		ms_state_next = ms_state_reg;
		wr_ptr_next   = wr_ptr_reg;
		rd_idx_next   = rd_idx_reg;
		len_next      = len_reg;
		comm_len_next = comm_len_reg;
		err_next      = err_reg;
		cr_pend_next  = cr_pend_reg;
		drop_next     = 1'b0;
		wr_en         = 1'b0;
		err_now       = err_reg;
		if (char_done_reg) begin
			if (comm_len_reg < MAX_COMM_LEN + ONE_LEN) begin
				comm_len_next = comm_len_reg + ONE_LEN;
			end
			err_now = err_reg || char_bad_reg || (comm_len_reg >= MAX_COMM_LEN);
			if (!char_bad_reg && (rx_shift_reg == CHAR_LF ||
				(rx_shift_reg == CHAR_SEMI && !cr_pend_reg))) begin
				if (!err_now && wr_ptr_reg != '0 && ms_state_reg == MS_COLLECT) begin
					ms_state_next = MS_FETCH;
					len_next      = wr_ptr_reg;
					rd_idx_next   = '0;
				end
				drop_next    = err_now;
				err_next     = 1'b0;
				wr_ptr_next  = '0;
				cr_pend_next = 1'b0;
				if (rx_shift_reg == CHAR_LF) begin
					comm_len_next = '0;
				end
			end else if (char_bad_reg || cr_pend_reg) begin
				// A carriage return must be followed at once by the line feed.
				err_next     = 1'b1;
				cr_pend_next = 1'b0;
			end else if (rx_shift_reg == CHAR_CR) begin
				cr_pend_next = 1'b1;
				err_next     = err_now;
			end else if (ms_state_reg != MS_COLLECT || err_now) begin
				err_next = 1'b1;
			end else begin
				wr_en       = 1'b1;
				wr_ptr_next = wr_ptr_reg + ONE_ADDR;
			end
		end
		unique case (ms_state_reg)
			MS_COLLECT: begin
			end
			MS_FETCH: begin
				ms_state_next = MS_SHOW;
			end
			MS_SHOW: begin
				if (msg_ready) begin
					if (msg_last) begin
						ms_state_next = MS_COLLECT;
					end else begin
						rd_idx_next   = rd_idx_reg + ONE_ADDR;
						ms_state_next = MS_FETCH;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ms_state_reg <= MS_COLLECT;
			wr_ptr_reg   <= '0;
			rd_idx_reg   <= '0;
			len_reg      <= '0;
			comm_len_reg <= '0;
			err_reg      <= 1'b0;
			cr_pend_reg  <= 1'b0;
			drop_reg     <= 1'b0;
		end else if (ce) begin
			ms_state_reg <= ms_state_next;
			wr_ptr_reg   <= wr_ptr_next;
			rd_idx_reg   <= rd_idx_next;
			len_reg      <= len_next;
			comm_len_reg <= comm_len_next;
			err_reg      <= err_next;
			cr_pend_reg  <= cr_pend_next;
			drop_reg     <= drop_next;
		end
	end

	char_buffer #(
		.WIDTH  (CHAR_W),
		.DEPTH  (BUF_DEPTH),
		.ADDR_W (ADDR_W)
	) u_buffer (
		.clk     (clk),
		.arst_n  (arst_n),
		.ce      (ce),
		.wr_en   (wr_en),
		.wr_addr (wr_ptr_reg),
		.wr_data (rx_shift_reg),
		.rd_addr (rd_idx_reg),
		.rd_data (msg_data)
	);

	assign msg_valid = (ms_state_reg == MS_SHOW);
	assign msg_last  = (rd_idx_reg == len_reg - ONE_ADDR);
	assign msg_drop  = drop_reg;

	// Transmitter: an offered character is loaded only once the transmitter is idle and no CR or LF of the last response is still due.
	always_comb begin
		load      = 1'b0;
		load_char = rsp_data;
		unique case (src_reg)
			SRC_USER: load = rsp_valid;
			SRC_CR: begin
				load      = 1'b1;
				load_char = CHAR_CR;
			end
			SRC_LF: begin
				load      = 1'b1;
				load_char = CHAR_LF;
			end
		endcase
		load = load && (tx_state_reg == TX_IDLE);
	end

	assign rsp_ready = (tx_state_reg == TX_IDLE) && (src_reg == SRC_USER);

	always_comb begin
		tx_state_next = tx_state_reg;
		src_next      = src_reg;
		tx_shift_next = tx_shift_reg;
		tx_bit_next   = tx_bit_reg;
		tx_cnt_next   = tx_cnt_reg + ONE_CNT;
		tx_pin_next   = tx_pin_reg;
		unique case (tx_state_reg)
			TX_IDLE: begin
				tx_cnt_next = '0;
				tx_pin_next = 1'b1;
				if (load) begin
					// Stop, odd parity, data, start; shifted out from bit zero.
					tx_shift_next = {1'b1, ~^load_char, load_char, 1'b0};
					tx_pin_next   = 1'b0;
					tx_bit_next   = '0;
					tx_state_next = TX_SEND;
					unique case (src_reg)
						SRC_USER: src_next = rsp_end ? SRC_CR : SRC_USER;
						SRC_CR:   src_next = SRC_LF;
						SRC_LF:   src_next = SRC_USER;
					endcase
				end
			end
			TX_SEND: begin
				if (tx_cnt_reg == BIT_CYCLES - ONE_CNT) begin
					tx_cnt_next   = '0;
					tx_shift_next = {1'b1, tx_shift_reg[FRAME_BITS-1:1]};
					tx_pin_next   = tx_shift_reg[1];
					tx_bit_next   = tx_bit_reg + 4'h1;
					if (tx_bit_reg == LAST_FRAME_BIT) begin
						tx_pin_next   = 1'b1;
						tx_state_next = TX_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_state_reg <= TX_IDLE;
			src_reg      <= SRC_USER;
			tx_shift_reg <= '1;
			tx_bit_reg   <= '0;
			tx_cnt_reg   <= '0;
			tx_pin_reg   <= 1'b1;
		end else if (ce) begin
			tx_state_reg <= tx_state_next;
			src_reg      <= src_next;
			tx_shift_reg <= tx_shift_next;
			tx_bit_reg   <= tx_bit_next;
			tx_cnt_reg   <= tx_cnt_next;
			tx_pin_reg   <= tx_pin_next;
		end
	end

	assign tx_pin = tx_pin_reg;
endmodule

// file: testbench/ascii_serial_message_port_assertions.sv
// Timing checker for the message port, bound to its top module.
`timescale 1ns/1ps
module port_checker (
	input wire logic                              clk,
	input wire logic                              arst_n,
	input wire logic                              ce,
	input wire logic                              rx_pin,
	input wire logic                              tx_pin,
	input wire logic [serial_msg_pkg::CHAR_W-1:0] msg_data,
	input wire logic                              msg_valid,
	input wire logic                              msg_last,
	input wire logic                              msg_ready,
	input wire logic                              msg_drop,
	input wire logic [serial_msg_pkg::CHAR_W-1:0] rsp_data,
	input wire logic                              rsp_valid,
	input wire logic                              rsp_end,
	input wire logic                              rsp_ready
);
	import serial_msg_pkg::*;
	logic [15:0] low_reg;
	logic [15:0] low_next;
	logic [15:0] busy_reg;
	logic [15:0] busy_next;
	// Run lengths count enabled cycles only, so a stretched bit still measures whole.
	always_comb begin
		low_next  = tx_pin ? 16'h0000 : low_reg + 16'(ce);
		busy_next = rsp_ready ? 16'h0000 : busy_reg + 16'(ce);
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			low_reg  <= 16'h0000;
			busy_reg <= 16'h0000;
		end else begin
			low_reg  <= low_next;
			busy_reg <= busy_next;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_start; rsp_valid && rsp_ready && ce |=> !tx_pin && !rsp_ready; endproperty
	a_start: assert property (p_start) else $error("no start bit after load");
	property p_bit_len; $rose(tx_pin) |-> (low_reg % BIT_CYCLES) == 0; endproperty
	a_bit_len: assert property (p_bit_len) else $error("low run not whole bits");
	property p_frame; $rose(rsp_ready) |-> busy_reg >= 16'(FRAME_BITS * BIT_CYCLES); endproperty
	a_frame: assert property (p_frame) else $error("frame too short");
	property p_idle; rsp_ready |-> tx_pin; endproperty
	a_idle: assert property (p_idle) else $error("line low while idle");
	property p_hold; msg_valid && !msg_ready |=> msg_valid && $stable(msg_data) && $stable(msg_last); endproperty
	a_hold: assert property (p_hold) else $error("message char not held");
	property p_fetch; msg_valid && msg_ready && ce |=> !msg_valid; endproperty
	a_fetch: assert property (p_fetch) else $error("valid after accept");
	property p_last; msg_valid && msg_last && msg_ready && ce |=> !msg_valid [*8]; endproperty
	a_last: assert property (p_last) else $error("char after message end");
	property p_drop; msg_drop |=> !msg_drop; endproperty
	a_drop: assert property (p_drop) else $error("drop pulse too long");
endmodule

bind ascii_serial_message_port port_checker port_checker_i (.clk(clk), .arst_n(arst_n),
	.ce(ce), .rx_pin(rx_pin), .tx_pin(tx_pin), .msg_data(msg_data), .msg_valid(msg_valid),
	.msg_last(msg_last), .msg_ready(msg_ready), .msg_drop(msg_drop), .rsp_data(rsp_data),
	.rsp_valid(rsp_valid), .rsp_end(rsp_end), .rsp_ready(rsp_ready));

// file: testbench/serial_host_model.sv
// Host side of the serial link: sends framed strings and decodes replies.
`timescale 1ns/1ps
module serial_host_model (
	input  wire logic clk,
	output logic      line_out,
	input  wire logic line_in
);
	import serial_msg_pkg::*;
	logic [7:0] rx_q[$];
	initial line_out = 1'b1;
	task automatic send_bit(input logic b);
		@(negedge clk);
		line_out = b;
		repeat (BIT_CYCLES - 1) @(negedge clk);
	endtask
	// A set bad flag inverts parity so the device sees a corrupted character.
	task automatic send_char(input logic [6:0] c, input logic bad);
		send_bit(1'b0);
		for (int i = 0; i < 7; i++) send_bit(c[i]);
		send_bit(~^c ^ bad);
		send_bit(1'b1);
	endtask
	// Strings stay short and always end in a terminator.
	task automatic send_str(input string s, input int bad);
		foreach (s[i]) send_char(7'(s[i]), i == bad);
	endtask
	// Each reply character is pushed with an error flag above its seven data bits.
	initial begin
		logic [8:0] sh;
		forever begin
			@(negedge line_in);
			repeat (HALF_BIT) @(posedge clk);
			for (int i = 0; i < 9; i++) begin
				repeat (BIT_CYCLES) @(posedge clk);
				sh[i] = line_in;
			end
			rx_q.push_back({~^sh[7:0] | ~sh[8], sh[6:0]});
		end
	end
endmodule

// file: testbench/ascii_serial_message_port_tb.sv
// Self-checking bench for the ASCII serial message port.
`timescale 1ns/1ps
module ascii_serial_message_port_tb;
	import serial_msg_pkg::*;
	logic              clk = 1'b0;
	logic              arst_n = 1'b1;
	logic              ce = 1'b1;
	logic              msg_ready = 1'b0;
	logic              rsp_valid = 1'b0;
	logic              rsp_end = 1'b0;
	logic [CHAR_W-1:0] rsp_data = 7'h00;
	logic              rx_pin;
	logic              tx_pin;
	logic              msg_valid;
	logic              msg_last;
	logic              msg_drop;
	logic              rsp_ready;
	logic [CHAR_W-1:0] msg_data;
	logic [7:0]        got_q[$];
	int                n_fail = 0;
	int                n_tests = 0;
	int                n_drop = 0;
	ascii_serial_message_port ascii_serial_message_port_i (.clk(clk), .arst_n(arst_n),
		.ce(ce), .rx_pin(rx_pin), .tx_pin(tx_pin), .msg_data(msg_data),
		.msg_valid(msg_valid), .msg_last(msg_last), .msg_ready(msg_ready),
		.msg_drop(msg_drop), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
		.rsp_end(rsp_end), .rsp_ready(rsp_ready));
	serial_host_model serial_host_model_i (.clk(clk), .line_out(rx_pin), .line_in(tx_pin));
	initial forever #25 clk = ~clk;
	// A toggling consumer makes the port hold characters across stalls.
	always @(negedge clk) msg_ready <= ~msg_ready;
	always @(posedge clk) begin
		if (msg_valid && msg_ready) got_q.push_back({msg_last, msg_data});
		if (msg_drop) n_drop++;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] pop_got();
		return got_q.size() ? {8'h00, got_q.pop_front()} : 16'hffff;
	endfunction
	task automatic expect_msg(input string m);
		foreach (m[i]) check(pop_got(), {8'h00, i == m.len() - 1, 7'(m[i])});
	endtask
	// The host quiet time is cut to a few cycles to keep the run short; the port keeps
	// no timer of its own, so a host that skips the full quiet time is not caught here.
	task automatic host_send(input string s, input int bad);
		serial_host_model_i.send_str(s, bad);
		repeat (20) @(negedge clk);
	endtask
	task automatic send_rsp(input logic [6:0] d, input logic last);
		@(negedge clk);
		rsp_valid = 1'b1;
		rsp_data = d;
		rsp_end = last;
		while (!rsp_ready) @(negedge clk);
		@(negedge clk);
		rsp_valid = 1'b0;
	endtask
	task automatic t_reset();
		check({12'h000, tx_pin, msg_valid, msg_drop, rsp_ready}, 16'h0009);
	endtask
	task automatic t_chain();
		host_send("A;B\r\n", -1);
		expect_msg("A");
		expect_msg("B");
		check(16'(got_q.size()), 16'h0000);
	endtask
	task automatic t_query();
		host_send("Q? 1\n", -1);
		expect_msg("Q? 1");
	endtask
	task automatic t_bad();
		n_drop = 0;
		host_send("XY\n", 0);
		check(16'(got_q.size()), 16'h0000);
		check(16'(n_drop), 16'h0001);
	endtask
	// An offer made while the clock enable is low must not start a frame.
	task automatic t_freeze();
		@(negedge clk);
		ce = 1'b0;
		rsp_valid = 1'b1;
		rsp_data = 7'h35;
		repeat (10) @(negedge clk);
		check({12'h000, tx_pin, msg_valid, msg_drop, rsp_ready}, 16'h0009);
		rsp_valid = 1'b0;
		@(negedge clk);
		ce = 1'b1;
		repeat (2) @(negedge clk);
		check({12'h000, tx_pin, msg_valid, msg_drop, rsp_ready}, 16'h0009);
	endtask
	task automatic t_rsp();
		logic [7:0] exp[4];
		exp = '{8'h34, 8'h32, {1'b0, CHAR_CR}, {1'b0, CHAR_LF}};
		send_rsp(7'h34, 1'b0);
		send_rsp(7'h32, 1'b1);
		for (int i = 0; i < 16000 && serial_host_model_i.rx_q.size() < 4; i++) @(negedge clk);
		foreach (exp[i]) check({8'h00, serial_host_model_i.rx_q.pop_front()}, {8'h00, exp[i]});
		check(16'(serial_host_model_i.rx_q.size()), 16'h0000);
	endtask
	task automatic results();
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		// Reset is lowered after time zero so the design sees a real falling edge.
		#1 arst_n = 1'b0;
		repeat (20) @(negedge clk);
		t_reset();
		arst_n = 1'b1;
		t_chain();
		t_query();
		t_bad();
		t_freeze();
		t_rsp();
		results();
	end
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		results();
	end
endmodule
